// File: logic/sync_burst_sram.sv
// What this block does
// R1: Holds 32768 words of nine bits, reached by a 15-bit address and a nine-bit data bus.
// R2: Address, write data and every control except output enable are captured on the rising clock edge.
// R3: A two-bit counter supplies the two low address bits during a burst.
// R4: A low processor start while selected aborts any burst and begins a read at the pin address.
// R5: A low cache start with the processor start high while selected begins a read or write burst per write_n.
// R6: The selects are looked at only on edges that load a new base address.
// R7: Selected means sel_hi high and sel_lo_n low; a start while not selected deselects the part.
// R8: With both starts high and burst_advance_n low the burst address steps before the access.
// R9: With both starts high and burst_advance_n high the address holds and the access repeats.
// R10: In continue and suspend cycles a low write_n writes and a high one reads.
// R11: A burst starts at the pin value of the low two bits and only those bits advance.
// R12: After the last position the burst wraps to its start and never carries upward.
// R13: Writes are timed inside from the sampling edge with no external pulse.
// R14: Read data drives the pins only while out_en_n is low during a read, otherwise the pins float.
// R15: One set of nine pins carries data both ways and the far side drives only while ours is off.
// R16: For a write after a read the far side raises out_en_n around the write data window.
// R17: The burst order is a linear count of the low two bits modulo four.
`include "sram_defs.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Write queue: first in, first out, with valid/ready on both sides.
// DEPTH must be a power of two, since the pointers wrap by overflow
// and the extra top bit tells a full queue from an empty one
module sram_write_queue #(
  parameter int WIDTH = `SRAM_WQ_WIDTH,
  parameter int DEPTH = `SRAM_WQ_DEPTH
) (
  input  wire logic             ref_clk,   // Clock
  input  wire logic             reset_n,   // Async reset, active low
  input  wire logic [WIDTH-1:0] in_data,   // Entry to store
  input  wire logic             in_valid,  // Entry offered
  output logic                  in_ready,  // Room for one entry
  output logic      [WIDTH-1:0] out_data,  // Oldest entry
  output logic                  out_valid, // Queue holds an entry
  input  wire logic             out_ready  // Drain accepts
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0]      wr_ptr_reg;
  logic [PW:0]      wr_ptr_next;
  logic [PW:0]      rd_ptr_reg;
  logic [PW:0]      rd_ptr_next;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr_reg[PW-1:0] != rd_ptr_reg[PW-1:0]) || (wr_ptr_reg[PW] == rd_ptr_reg[PW]);
  assign out_valid = (wr_ptr_reg != rd_ptr_reg);
  assign out_data  = store[rd_ptr_reg[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer advance
  always_comb begin
    wr_ptr_next = push ? wr_ptr_reg + (PW+1)'(1) : wr_ptr_reg;
    rd_ptr_next = pop ? rd_ptr_reg + (PW+1)'(1) : rd_ptr_reg;
  end

  // Pointer registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage needs no reset; only pointers say what is valid
  always_ff @(posedge ref_clk) begin
    if (push) begin
      store[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end
endmodule : sram_write_queue

////////////////////////////////////////////////////////////////////////////////
// Synchronous burst memory, 32K x 9
module sync_burst_sram (
  input  wire logic                    ref_clk,            // Memory clock
  input  wire logic                    reset_n,            // Async reset, active low
  input  wire logic [`SRAM_ADDR_W-1:0] addr_in,            // External address
  input  wire logic                    proc_xfer_start_n,  // Processor start, low active
  input  wire logic                    cache_xfer_start_n, // Cache start, low active
  input  wire logic                    burst_advance_n,    // Advance, low active
  input  wire logic                    write_n,            // Write, low active
  input  wire logic                    sel_hi,             // Select, high active
  input  wire logic                    sel_lo_n,           // Select, low active
  input  wire logic                    out_en_n,           // Async output enable, low active
  input  wire logic [`SRAM_DATA_W-1:0] data_i,             // Data pins, incoming
  output logic      [`SRAM_DATA_W-1:0] data_o,             // Data pins, outgoing
  output logic                         data_oe,            // Pins driven when high
  output logic                         wr_ready            // Write queue has room
);

  ////////////////////////////////////////////////////////////////////////////
  // Input registers, all synchronous pins except out_en_n
  logic [`SRAM_ADDR_W-1:0] addr_q_reg;
  logic [`SRAM_ADDR_W-1:0] addr_q_next;
  logic [`SRAM_DATA_W-1:0] data_q_reg;
  logic [`SRAM_DATA_W-1:0] data_q_next;
  logic                    psn_q_reg;
  logic                    psn_q_next;
  logic                    csn_q_reg;
  logic                    csn_q_next;
  logic                    advn_q_reg;
  logic                    advn_q_next;
  logic                    wn_q_reg;
  logic                    wn_q_next;
  logic                    shi_q_reg;
  logic                    shi_q_next;
  logic                    slon_q_reg;
  logic                    slon_q_next;

  // Pins are timed to ref_clk by the far side, so one register level only;
  // a second stage would add a cycle to every access and break the timing
  // that the far side counts on
  always_comb begin
    addr_q_next = addr_in;            // R2
    data_q_next = data_i;             // R2 R15
    psn_q_next  = proc_xfer_start_n;  // R2
    csn_q_next  = cache_xfer_start_n; // R2
    advn_q_next = burst_advance_n;    // R2
    wn_q_next   = write_n;            // R2
    shi_q_next  = sel_hi;             // R2
    slon_q_next = sel_lo_n;           // R2
  end

  // Reset values read as no start, no advance, read, not selected
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q_reg <= `SRAM_ADDR_RST;
      data_q_reg <= `SRAM_DATA_RST;
      psn_q_reg  <= 1'b1;
      csn_q_reg  <= 1'b1;
      advn_q_reg <= 1'b1;
      wn_q_reg   <= 1'b1;
      shi_q_reg  <= 1'b0;
      slon_q_reg <= 1'b1;
    end else begin
      addr_q_reg <= addr_q_next;
      data_q_reg <= data_q_next;
      psn_q_reg  <= psn_q_next;
      csn_q_reg  <= csn_q_next;
      advn_q_reg <= advn_q_next;
      wn_q_reg   <= wn_q_next;
      shi_q_reg  <= shi_q_next;
      slon_q_reg <= slon_q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst control
  // active_reg marks a selected burst in progress; continues need it
  logic [`SRAM_ADDR_W-1:0] base_reg;
  logic [`SRAM_ADDR_W-1:0] base_next;
  logic [`SRAM_CNT_W-1:0]  cnt_reg;
  logic [`SRAM_CNT_W-1:0]  cnt_next;
  logic                    active_reg;
  logic                    active_next;
  sram_pkg::op_t           op;
  logic                    selected;

  // Both selects must agree; either one alone deselects
  assign selected = shi_q_reg && !slon_q_reg; // R7

  // Decode of the sampled controls; processor start has priority.
  // Starts reload base and counter even when deselected, which is harmless:
  // active_reg stays low and no access uses them until a selected start
  always_comb begin
    base_next   = base_reg;
    cnt_next    = cnt_reg;
    active_next = active_reg;
    op          = sram_pkg::OP_IDLE;
    if (!psn_q_reg) begin
      active_next = selected;                           // R4 R6 R7
      base_next   = addr_q_reg;                         // R4
      cnt_next    = addr_q_reg[`SRAM_CNT_W-1:0];        // R11
      op          = selected ? sram_pkg::OP_READ : sram_pkg::OP_IDLE; // R4
    end else if (!csn_q_reg) begin
      active_next = selected;                           // R5 R6 R7
      base_next   = addr_q_reg;                         // R5
      cnt_next    = addr_q_reg[`SRAM_CNT_W-1:0];        // R11
      if (selected) begin
        op = wn_q_reg ? sram_pkg::OP_READ : sram_pkg::OP_WRITE; // R5
      end
    end else if (active_reg) begin
      // Selects are not looked at here
      if (!advn_q_reg) begin
        cnt_next = cnt_reg + `SRAM_CNT_STEP;            // R8 R12 R17
      end
      op = wn_q_reg ? sram_pkg::OP_READ : sram_pkg::OP_WRITE; // R9 R10
    end
  end

  // Burst state registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      base_reg   <= `SRAM_ADDR_RST;
      cnt_reg    <= `SRAM_CNT_RST;
      active_reg <= 1'b0;
    end else begin
      base_reg   <= base_next;
      cnt_reg    <= cnt_next;
      active_reg <= active_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access address: upper bits fixed by the base, low bits from the counter.
  // Built from the next values so an advance steps before its own access
  // rather than one cycle late
  logic [`SRAM_ADDR_W-1:0] acc_addr;

  assign acc_addr = {base_next[`SRAM_ADDR_W-1:`SRAM_UPPER_LSB], cnt_next}; // R3 R11

  ////////////////////////////////////////////////////////////////////////////
  // Write queue between the capture stage and the array
  logic [`SRAM_WQ_WIDTH-1:0] wq_in;
  logic [`SRAM_WQ_WIDTH-1:0] wq_out;
  logic                      wq_push;
  logic                      wq_valid;
  logic                      wq_drain;
  logic                      wq_hit;

  // Entry is the access address above the write data
  assign wq_in    = {acc_addr, data_q_reg};
  assign wq_push  = (op == sram_pkg::OP_WRITE); // R13
  // A read owns the single array port, so the queue stalls under reads.
  // Writes push only in cycles that also drain, so at most one entry waits;
  // the queue depth is headroom, not a backlog that reads must search
  assign wq_drain = (op != sram_pkg::OP_READ);
  // Read of the word still waiting in the queue takes the queued data
  assign wq_hit   = wq_valid && (wq_out[`SRAM_WQ_WIDTH-1:`SRAM_DATA_W] == acc_addr); // R1 R13

  sram_write_queue #(
    .WIDTH (`SRAM_WQ_WIDTH),
    .DEPTH (`SRAM_WQ_DEPTH)
  ) sram_write_queue_inst (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_data   (wq_in),
    .in_valid  (wq_push),
    .in_ready  (wr_ready),
    .out_data  (wq_out),
    .out_valid (wq_valid),
    .out_ready (wq_drain)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Array and read path
  logic [`SRAM_DATA_W-1:0] mem [`SRAM_WORDS]; // R1
  logic [`SRAM_DATA_W-1:0] rd_data_reg;
  logic [`SRAM_DATA_W-1:0] rd_data_next;
  logic                    rd_valid_reg;
  logic                    rd_valid_next;

  // Self-timed write: a queued entry lands on the next free edge
  always_ff @(posedge ref_clk) begin
    if (wq_valid && wq_drain) begin
      mem[wq_out[`SRAM_WQ_WIDTH-1:`SRAM_DATA_W]] <= wq_out[`SRAM_DATA_W-1:0]; // R13
    end
  end

  // Read data captured at the access edge; held through waits and idles so
  // data_o changes only on reads; data_oe still floats the pins once rd_valid_reg drops
  always_comb begin
    rd_valid_next = (op == sram_pkg::OP_READ);
    rd_data_next  = rd_data_reg;
    if (rd_valid_next) begin
      if (wq_hit) begin
        // Queued write not yet in the array; bypass keeps reads coherent
        rd_data_next = wq_out[`SRAM_DATA_W-1:0]; // R1 R13
      end else begin
        rd_data_next = mem[acc_addr];            // R9 R10
      end
    end
  end

  // Read stage registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_reg  <= `SRAM_DATA_RST;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  // Enable is asynchronous on purpose, so it gates the drive directly;
  // registering it would cost a whole cycle on a late enable
  assign data_o  = rd_data_reg;
  assign data_oe = rd_valid_reg && !out_en_n; // R14 R15 R16

endmodule : sync_burst_sram
`default_nettype wire

// File: logic/sram_defs.svh
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

// Array geometry
`define SRAM_ADDR_W     15
`define SRAM_DATA_W     9
`define SRAM_WORDS      32768
`define SRAM_CNT_W      2
`define SRAM_UPPER_LSB  2

// Burst counter step and reset values
`define SRAM_CNT_STEP   2'h1
`define SRAM_CNT_RST    2'h0
`define SRAM_ADDR_RST   15'h0000
`define SRAM_DATA_RST   9'h000

// Write queue in front of the array
`define SRAM_WQ_DEPTH   32
`define SRAM_WQ_WIDTH   24

`endif

// File: logic/sram_pkg.sv
`default_nettype none
package sram_pkg;

  // Access chosen for one clock, Gray along idle -> read -> write
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b11
  } op_t;

endpackage : sram_pkg
`default_nettype wire

// File: tb/sync_burst_sram_checker.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
// Port watch over the burst memory; outputs lag samples by two edges
module sync_burst_sram_checker (
  input wire logic       ref_clk,            // Clock
  input wire logic       reset_n,            // Reset
  input wire logic       proc_xfer_start_n,  // Proc start
  input wire logic       cache_xfer_start_n, // Cache start
  input wire logic       burst_advance_n,    // Advance
  input wire logic       write_n,            // Write
  input wire logic       sel_hi,             // Select
  input wire logic       sel_lo_n,           // Select
  input wire logic       out_en_n,           // Enable
  input wire logic [8:0] data_o,             // Read data
  input wire logic       data_oe,            // Driving
  input wire logic       wr_ready            // Room
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic sel;
  logic p;
  logic c;
  // Short aliases keep each property on its lines
  assign sel = sel_hi && !sel_lo_n;
  assign p = proc_xfer_start_n;
  assign c = cache_xfer_start_n;
  a_proc_read: assert property (!p && sel |-> ##2 (data_oe == !out_en_n)) else $error("no read");
  a_oe_off: assert property (out_en_n |-> !data_oe) else $error("drives with enable off");
  a_write_float: assert property (p && !c && sel && !write_n |-> ##2 !data_oe) else $error("write drove");
  a_desel_float: assert property ((!p || !c) && !sel |-> ##2 !data_oe) else $error("deselect drove");
  a_oe_cause: assert property (data_oe |-> $past(write_n, 2) || !$past(p, 2)) else $error("drive without read");
  a_sel_ignored: assert property (!p && sel ##1 (p && c && !burst_advance_n && write_n)
    |-> ##2 (data_oe == !out_en_n)) else $error("continue dropped");
  a_suspend_same: assert property ((!p || (!c && write_n)) && sel ##1 (p && c && burst_advance_n && write_n)
    |-> ##2 $stable(data_o)) else $error("suspend moved");
  a_write_room: assert property (wr_ready) else $error("write refused");
  c_proc_read: cover property (!p && sel ##2 data_oe);
  c_cache_write: cover property (p && !c && sel && !write_n);
  c_suspend: cover property (p && c && burst_advance_n ##2 data_oe);
endmodule : sync_burst_sram_checker
bind sync_burst_sram sync_burst_sram_checker sync_burst_sram_checker_inst (.ref_clk(ref_clk),
  .reset_n(reset_n), .proc_xfer_start_n(proc_xfer_start_n), .cache_xfer_start_n(cache_xfer_start_n),
  .burst_advance_n(burst_advance_n), .write_n(write_n), .sel_hi(sel_hi), .sel_lo_n(sel_lo_n),
  .out_en_n(out_en_n), .data_o(data_o), .data_oe(data_oe), .wr_ready(wr_ready));
`default_nettype wire

// File: tb/bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side party: owns the shared pins and the output enable
module bus_partner (
  input  wire logic       ref_clk,   // Clock
  input  wire logic       drive_en,  // Write data offered
  input  wire logic [8:0] drive_val, // Write data
  input  wire logic       oe_req,    // Wants read data
  input  wire logic [8:0] data_o,    // Device data
  input  wire logic       data_oe,   // Device drives
  output logic      [8:0] data_i,    // Pin level
  output logic            out_en_n   // Enable, low active
);
  logic [8:0] last_reg = 9'h000;
  // Enable held off while we drive, so the two never fight
  assign out_en_n = !oe_req || drive_en;
  // Released pins show the inverse of the last level, not a stale copy
  assign data_i = data_oe ? data_o : (drive_en ? drive_val : ~last_reg);
  always_ff @(posedge ref_clk) begin
    last_reg <= data_i;
  end
endmodule : bus_partner
`default_nettype wire

// File: tb/sync_burst_sram_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sync_burst_sram_tb;
  localparam logic [14:0] base = 15'h7FFE;
  localparam logic [8:0]  d0 = 9'h1A5, d1 = 9'h05A, d2 = 9'h133, d3 = 9'h0CC, d4 = 9'h1F0;
  // Control codes {proc, cache, advance, write, select}
  localparam logic [4:0]  rd_p = 5'h0F, rd_pcw = 5'h05, rd_c = 5'h17, wr_c = 5'h15, wr_cns = 5'h14;
  localparam logic [4:0]  adv_wr = 5'h19, adv_wrns = 5'h18, sus_wr = 5'h1D, adv_rd = 5'h1B;
  localparam logic [4:0]  adv_rdns = 5'h1A, sus_rd = 5'h1F;
  logic        ref_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic [14:0] addr = 15'h0000;
  logic        ps_n = 1'h1, cs_n = 1'h1, adv_n = 1'h1, wr_n = 1'h1, s_hi = 1'h0, s_lo_n = 1'h1;
  logic        drv_en = 1'h0, oe_req = 1'h1, oe_n, doe, wrdy, oe_seen;
  logic [8:0]  drv_val = 9'h000, di, dq, q_seen;
  int          err_total = 0, n_tests = 0;

  sync_burst_sram sync_burst_sram_inst (.ref_clk(ref_clk), .reset_n(reset_n), .addr_in(addr),
    .proc_xfer_start_n(ps_n), .cache_xfer_start_n(cs_n), .burst_advance_n(adv_n), .write_n(wr_n),
    .sel_hi(s_hi), .sel_lo_n(s_lo_n), .out_en_n(oe_n), .data_i(di), .data_o(dq), .data_oe(doe),
    .wr_ready(wrdy));
  bus_partner bus_partner_inst (.ref_clk(ref_clk), .drive_en(drv_en), .drive_val(drv_val),
    .oe_req(oe_req), .data_o(dq), .data_oe(doe), .data_i(di), .out_en_n(oe_n));

  always #12.5 ref_clk = !ref_clk;
  // Pins looked at mid-cycle, where they have settled
  always @(negedge ref_clk) begin
    q_seen <= dq;
    oe_seen <= doe;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk
  // One cycle; judges the request made two calls back (e: 0 none, 1 idle pins, 2 read data)
  task automatic step(input logic [4:0] k, input logic [14:0] ad, input logic [8:0] d,
                      input logic [1:0] e, input logic [8:0] eq);
    {ps_n, cs_n, adv_n, wr_n, s_hi} <= k;
    s_lo_n <= !k[0];
    drv_en <= k[4] && !k[1];
    addr <= ad;
    drv_val <= d;
    @(posedge ref_clk);
    if (e != 2'h0) chk("data_oe", {8'h00, e == 2'h2}, {8'h00, oe_seen});
    if (e == 2'h2) chk("data_o", eq, q_seen);
  endtask : step
  // Processor start while deselected ends any burst
  task automatic idle(input logic [1:0] e, input logic [8:0] eq);
    step(5'h0E, 15'h0000, 9'h000, e, eq);
  endtask : idle
  task automatic t_write_burst();
    step(wr_c, base, d0, 2'h1, 9'h000);
    step(adv_wrns, 15'h0000, d1, 2'h1, 9'h000);
    step(adv_wr, 15'h0000, d2, 2'h1, 9'h000);
    step(adv_wr, 15'h0000, d3, 2'h1, 9'h000);
    step(sus_wr, 15'h0000, d4, 2'h1, 9'h000);
    step(wr_cns, base, 9'h0FF, 2'h1, 9'h000);
    step(adv_wr, 15'h0000, 9'h0FF, 2'h1, 9'h000);
    idle(2'h1, 9'h000);
    $display("test write_burst done");
  endtask : t_write_burst
  // Processor start wins over cache start and write; wraps without carry
  task automatic t_read_burst();
    step(rd_pcw, base, 9'h000, 2'h1, 9'h000);
    step(adv_rd, 15'h0000, 9'h000, 2'h1, 9'h000);
    step(adv_rd, 15'h0000, 9'h000, 2'h2, d0);
    step(adv_rd, 15'h0000, 9'h000, 2'h2, d1);
    step(adv_rd, 15'h0000, 9'h000, 2'h2, d2);
    step(sus_rd, 15'h0000, 9'h000, 2'h2, d4);
    idle(2'h2, d0);
    idle(2'h2, d0);
    idle(2'h1, 9'h000);
    $display("test read_burst done");
  endtask : t_read_burst
  task automatic t_select_rules();
    step(rd_p, 15'h7FFF, 9'h000, 2'h1, 9'h000);
    step(adv_rdns, 15'h0000, 9'h000, 2'h1, 9'h000);
    idle(2'h2, d1);
    step(adv_rd, 15'h0000, 9'h000, 2'h2, d2);
    idle(2'h1, 9'h000);
    idle(2'h1, 9'h000);
    $display("test select_rules done");
  endtask : t_select_rules
  // Enable acts at once, without waiting for a clock
  task automatic t_oe_async();
    step(rd_c, base, 9'h000, 2'h1, 9'h000);
    step(sus_rd, 15'h0000, 9'h000, 2'h1, 9'h000);
    oe_req <= 1'h0;
    step(sus_rd, 15'h0000, 9'h000, 2'h1, 9'h000);
    oe_req <= 1'h1;
    idle(2'h2, d0);
    idle(2'h2, d0);
    idle(2'h1, 9'h000);
    $display("test oe_async done");
  endtask : t_oe_async
  // Read right behind a write to the same word sees the new data
  task automatic t_write_read();
    step(wr_c, 15'h1234, 9'h0AB, 2'h1, 9'h000);
    step(rd_p, 15'h1234, 9'h000, 2'h1, 9'h000);
    idle(2'h1, 9'h000);
    idle(2'h2, 9'h0AB);
    idle(2'h1, 9'h000);
    chk("wr_ready", 9'h001, {8'h00, wrdy});
    $display("test write_read done");
  endtask : t_write_read
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  // Tests need about 50 cycles; far more means a hang
  initial begin
    repeat (2000) @(posedge ref_clk);
    err_total++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    chk("reset data_o", 9'h000, dq);
    chk("reset data_oe", 9'h000, {8'h00, doe});
    chk("reset wr_ready", 9'h001, {8'h00, wrdy});
    reset_n <= 1'h1;
    idle(2'h0, 9'h000);
    idle(2'h0, 9'h000);
    t_write_burst();
    t_read_burst();
    t_select_rules();
    t_oe_async();
    t_write_read();
    stop_test();
  end
endmodule : sync_burst_sram_tb
`default_nettype wire
